/* fsps_map.svh */
// Constants and register map of the flash self-program sequencer
`ifndef FSPS_MAP_SVH
`define FSPS_MAP_SVH
// ==========================================================================
// Register offsets
`define FSPS_CTRL_ADDR      8'h57
`define FSPS_STAT_ADDR      8'h58
// ==========================================================================
// Field layout and command codes
`define FSPS_CMD_MASK       8'h3F
`define FSPS_CMD_LOAD       8'h01
`define FSPS_CMD_ERASE      8'h03
`define FSPS_CMD_WRITE      8'h05
`define FSPS_CMD_FUSE       8'h09
`define FSPS_CMD_CLEAR      8'h11
`define FSPS_CMD_SIG        8'h21
`define FSPS_CTRL_RESET     8'h00
`define FSPS_ARM_BIT        0
`define FSPS_WORD_LSB       1
`define FSPS_WORD_MSB       4
`define FSPS_PAGE_LSB       5
`define FSPS_PAGE_MSB       11
`define FSPS_WORDS          16
`define FSPS_LAST_WORD      4'hF
`define FSPS_FUSE_SYNC_RST  2'h3
// ==========================================================================
// Timing
`define FSPS_ARM_WINDOW     3'h4
`define FSPS_READ_WINDOW    3'h3
`define FSPS_CLK_MHZ        100
`define FSPS_PROG_MIN_US    3700
`define FSPS_PROG_CYCLES    (`FSPS_PROG_MIN_US * `FSPS_CLK_MHZ)
`endif

/* fsps_pkg.sv */
// Types of the flash self-program sequencer
package fsps_pkg;
  typedef enum logic [3:0] {
    FSPS_IDLE  = 4'b0001,
    FSPS_ARMED = 4'b0010,
    FSPS_BUSY  = 4'b0100,
    FSPS_READ  = 4'b1000
  } fsps_state_t;
  typedef logic [15:0] fsps_word_t;
endpackage

/* fsps_sequencer.sv */
// Flash self-program sequencer: control register, page buffer, timed erase and write
`timescale 1ns/100ps
`include "fsps_map.svh"
module fsps_sequencer #(
  parameter int unsigned PROG_CYCLES = `FSPS_PROG_CYCLES
) (
  input  wire logic               CLOCK,
  input  wire logic               SRST,
  input  wire logic [7:0]         REG_ADDR,
  input  wire logic [7:0]         REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output logic      [7:0]         REG_RDATA,
  input  wire logic               STORE_PROGRAM,
  input  wire logic               LOAD_PROGRAM,
  input  wire logic [15:0]        POINTER,
  input  wire fsps_pkg::fsps_word_t DATA_PAIR,
  input  wire logic               SELF_PROGRAM_FUSE_N,
  input  wire logic               EEPROM_WRITE_BUSY,
  input  wire logic [7:0]         FUSE_LOCK_BITS,
  output logic                    CPU_HALT,
  output logic                    FLASH_ERASE,
  output logic                    FLASH_WRITE,
  output logic [6:0]              FLASH_PAGE,
  output fsps_pkg::fsps_word_t    FLASH_WDATA,
  output logic [3:0]              FLASH_WORD,
  output logic                    LOAD_BYTE_HIGH,
  output logic [7:0]              LOAD_RDATA,
  output logic                    LOAD_RVALID
);
  import fsps_pkg::*;

  // ========================================================================
  // Synchronised pins
  logic [1:0]          fuse_sync;
  logic [1:0]          eep_sync;
  logic                fuse_ok;
  logic                eep_busy;

  // Two-stage synchronisers for fuse and EEPROM busy
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      fuse_sync <= `FSPS_FUSE_SYNC_RST;
      eep_sync  <= 2'h0;
    end else begin
      fuse_sync <= {fuse_sync[0], SELF_PROGRAM_FUSE_N};
      eep_sync  <= {eep_sync[0], EEPROM_WRITE_BUSY};
    end
  end
  assign fuse_ok  = ~fuse_sync[1];
  assign eep_busy = eep_sync[1];

  // ========================================================================
  // Command decode
  fsps_state_t         state;
  logic [7:0]          ctrl;
  logic [2:0]          arm_cnt;
  logic [31:0]         prog_cnt;
  logic                ctrl_wr;
  logic                cmd_valid;
  logic                store_ok;
  logic                prog_start;

  // Lower six bits must match a listed command
  function automatic logic fsps_legal(input logic [7:0] v);
    logic [7:0] c;
    c = v & `FSPS_CMD_MASK;
    fsps_legal = (c == `FSPS_CMD_LOAD) || (c == `FSPS_CMD_ERASE) ||
                 (c == `FSPS_CMD_WRITE) || (c == `FSPS_CMD_FUSE) ||
                 (c == `FSPS_CMD_CLEAR) || (c == `FSPS_CMD_SIG);
  endfunction

  // Erase and write are the two timed operations that halt the core
  function automatic logic fsps_is_prog(input logic [7:0] c);
    fsps_is_prog = (c == `FSPS_CMD_ERASE) || (c == `FSPS_CMD_WRITE);
  endfunction

  assign ctrl_wr = REG_WR && (REG_ADDR == `FSPS_CTRL_ADDR);
  // illegal patterns ignored; blocked while EEPROM busy
  assign cmd_valid = ctrl_wr && fsps_legal(REG_WDATA) && !eep_busy &&
                     (state == FSPS_IDLE);
  // store acts only when armed and fuse programmed
  assign store_ok = STORE_PROGRAM && (state == FSPS_ARMED) && fuse_ok && !eep_busy;
  // armed erase or write store starts the timed run
  assign prog_start = store_ok && fsps_is_prog(ctrl);

  // ========================================================================
  // Sequencer state, control register and timers
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state    <= FSPS_IDLE;
      ctrl     <= `FSPS_CTRL_RESET;
      arm_cnt  <= 3'h0;
      prog_cnt <= 32'h0;
    end else begin
      case (state)
        FSPS_IDLE: begin
          if (cmd_valid) begin
            ctrl    <= REG_WDATA & `FSPS_CMD_MASK;
            arm_cnt <= ((REG_WDATA & `FSPS_CMD_MASK) == `FSPS_CMD_LOAD ||
                        (REG_WDATA & `FSPS_CMD_MASK) == `FSPS_CMD_ERASE ||
                        (REG_WDATA & `FSPS_CMD_MASK) == `FSPS_CMD_WRITE)
                       ? `FSPS_ARM_WINDOW : `FSPS_READ_WINDOW;
            state   <= ((REG_WDATA & `FSPS_CMD_MASK) == `FSPS_CMD_CLEAR)
                       ? FSPS_IDLE : FSPS_ARMED;
            if ((REG_WDATA & `FSPS_CMD_MASK) == `FSPS_CMD_CLEAR) begin
              ctrl <= `FSPS_CTRL_RESET;
            end
          end
        end
        FSPS_ARMED: begin
          // self-clear after a load store or when window lapses
          if (prog_start) begin
            state    <= FSPS_BUSY;
            prog_cnt <= PROG_CYCLES - 1;
          end else if ((store_ok && ctrl == `FSPS_CMD_LOAD) || arm_cnt <= 3'h1) begin
            state <= FSPS_IDLE;
            ctrl  <= `FSPS_CTRL_RESET;
          end else begin
            arm_cnt <= arm_cnt - 3'h1;
          end
        end
        FSPS_BUSY: begin
          // hold for the minimum programming time
          if (prog_cnt == 32'h0) begin
            state <= FSPS_IDLE;
            ctrl  <= `FSPS_CTRL_RESET;
          end else begin
            prog_cnt <= prog_cnt - 32'h1;
          end
        end
        default: begin
          state <= FSPS_IDLE;
          ctrl  <= `FSPS_CTRL_RESET;
        end
      endcase
    end
  end

  // ========================================================================
  // Temporary page buffer
  fsps_word_t          buf_data [`FSPS_WORDS];
  logic [`FSPS_WORDS-1:0] buf_used;
  logic [3:0]          word_idx;
  logic                buf_clear;
  logic                load_en;
  logic                write_done;

  // word field above unused bit zero
  assign word_idx   = POINTER[`FSPS_WORD_MSB:`FSPS_WORD_LSB];
  // one word per armed load store
  assign load_en    = store_ok && (ctrl == `FSPS_CMD_LOAD);
  assign write_done = (state == FSPS_BUSY) && (prog_cnt == 32'h0) &&
                      (ctrl == `FSPS_CMD_WRITE);
  // clear after write or clear command; EEPROM write discards
  assign buf_clear  = write_done || eep_busy ||
                      (cmd_valid && (REG_WDATA & `FSPS_CMD_MASK) == `FSPS_CMD_CLEAR);

  genvar gi;
  generate
    for (gi = 0; gi < `FSPS_WORDS; gi++) begin : g_buf
      // any word index, each its own slot
      always_ff @(posedge CLOCK) begin
        if (SRST || buf_clear) begin
          buf_data[gi] <= 16'h0000;
          buf_used[gi] <= 1'b0;
        end else if (load_en && word_idx == 4'(gi) && !buf_used[gi]) begin
          buf_data[gi] <= DATA_PAIR;
          buf_used[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // ========================================================================
  // Flash operation outputs
  logic [6:0]          page_lat;
  logic [3:0]          out_idx;
  logic [6:0]          page_field;

  // page field sits above the word field
  assign page_field = POINTER[`FSPS_PAGE_MSB:`FSPS_PAGE_LSB];

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      page_lat <= 7'h00;
    end else if (prog_start) begin
      page_lat <= page_field;
    end
  end

  // Stream buffer words into flash during a page write
  always_ff @(posedge CLOCK) begin
    if (SRST || state != FSPS_BUSY) begin
      out_idx <= 4'h0;
    end else if (ctrl == `FSPS_CMD_WRITE && out_idx != `FSPS_LAST_WORD) begin
      out_idx <= out_idx + 4'h1;
    end
  end

  // halt CPU while erase or write runs; erase and write pulses
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      CPU_HALT    <= 1'b0;
      FLASH_ERASE <= 1'b0;
      FLASH_WRITE <= 1'b0;
      FLASH_PAGE  <= 7'h00;
      FLASH_WDATA <= 16'h0000;
      FLASH_WORD  <= 4'h0;
    end else begin
      CPU_HALT    <= (state == FSPS_BUSY) ||
                     prog_start;
      FLASH_ERASE <= (state == FSPS_BUSY) && (ctrl == `FSPS_CMD_ERASE);
      // write streams buffer words to latched page
      FLASH_WRITE <= (state == FSPS_BUSY) && (ctrl == `FSPS_CMD_WRITE);
      FLASH_PAGE  <= page_lat;
      FLASH_WDATA <= buf_data[out_idx];
      FLASH_WORD  <= out_idx;
    end
  end

  // ========================================================================
  // Load instruction and register reads
  // byte select from pointer bit zero; fuse read blocked while busy
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      LOAD_BYTE_HIGH <= 1'b0;
      LOAD_RDATA     <= 8'h00;
      LOAD_RVALID    <= 1'b0;
    end else begin
      LOAD_BYTE_HIGH <= POINTER[0];
      LOAD_RVALID    <= LOAD_PROGRAM && state == FSPS_ARMED &&
                        ctrl == `FSPS_CMD_FUSE && !eep_busy;
      LOAD_RDATA     <= (LOAD_PROGRAM && state == FSPS_ARMED &&
                         ctrl == `FSPS_CMD_FUSE && !eep_busy) ? FUSE_LOCK_BITS : 8'h00;
    end
  end

  // Register read data one cycle after the strobe
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD && REG_ADDR == `FSPS_CTRL_ADDR) begin
      REG_RDATA <= ctrl;
    end else if (REG_RD && REG_ADDR == `FSPS_STAT_ADDR) begin
      REG_RDATA <= {5'h00, eep_busy, fuse_ok, state == FSPS_BUSY};
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // ========================================================================
  // Checks
  // arm lapses after four cycles, three for fuse and signature reads
  arm_lapse_a: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == FSPS_ARMED && !STORE_PROGRAM)[*4] |=> state == FSPS_IDLE)
    else $error("arm window not closed");
  halt_busy_a: assert property (@(posedge CLOCK) disable iff (SRST)
    state == FSPS_BUSY |=> CPU_HALT) else $error("cpu not halted");
  unarmed_store_a: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == FSPS_IDLE && !eep_busy) |=> $stable(buf_used) || $fell(|buf_used))
    else $error("buffer changed unarmed");
  fuse_block_a: assert property (@(posedge CLOCK) disable iff (SRST)
    (STORE_PROGRAM && !fuse_ok && state == FSPS_ARMED) |=> state != FSPS_BUSY)
    else $error("store ran with fuse off");
  eep_block_a: assert property (@(posedge CLOCK) disable iff (SRST)
    (eep_busy && state == FSPS_IDLE) |=> state == FSPS_IDLE)
    else $error("armed during EEPROM write");
  bad_cmd_a: assert property (@(posedge CLOCK) disable iff (SRST)
    (ctrl_wr && !fsps_legal(REG_WDATA) && state == FSPS_IDLE) |=> $stable(ctrl))
    else $error("illegal command took effect");
  write_clear_a: assert property (@(posedge CLOCK) disable iff (SRST)
    write_done |=> buf_used == '0) else $error("buffer not cleared");
  load_word_a: assert property (@(posedge CLOCK) disable iff (SRST)
    load_en && !buf_clear |=> buf_used[$past(word_idx)]) else $error("word not loaded");
  page_hold_a: assert property (@(posedge CLOCK) disable iff (SRST)
    state == FSPS_BUSY |=> $stable(page_lat)) else $error("page changed");
  start_halt_a: assert property (@(posedge CLOCK) disable iff (SRST)
    prog_start |=> state == FSPS_BUSY && CPU_HALT)
    else $error("timed run not started");
  // page taken from pointer at store
  page_latch_a: assert property (@(posedge CLOCK) disable iff (SRST)
    prog_start |=> page_lat == $past(page_field))
    else $error("page not latched");
  // busy timer counts down by one
  busy_count_a: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == FSPS_BUSY && prog_cnt != 32'h0) |=>
      (state == FSPS_BUSY && prog_cnt == $past(prog_cnt) - 32'h1))
    else $error("programming timer broken");
  // arm bit drops when the run ends
  busy_end_a: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == FSPS_BUSY && prog_cnt == 32'h0) |=>
      (state == FSPS_IDLE && ctrl == `FSPS_CTRL_RESET))
    else $error("run did not end");
  // arm bit drops after a load
  load_leaves_a: assert property (@(posedge CLOCK) disable iff (SRST)
    load_en |=> state == FSPS_IDLE && ctrl == `FSPS_CTRL_RESET)
    else $error("arm held after load");
  clear_cmd_a: assert property (@(posedge CLOCK) disable iff (SRST)
    (cmd_valid && (REG_WDATA & `FSPS_CMD_MASK) == `FSPS_CMD_CLEAR) |=> buf_used == '0)
    else $error("buffer not cleared by command");
  eep_discard_a: assert property (@(posedge CLOCK) disable iff (SRST)
    eep_busy |=> buf_used == '0)
    else $error("buffer kept during EEPROM write");
  // no fuse read while EEPROM busy
  eep_read_a: assert property (@(posedge CLOCK) disable iff (SRST)
    eep_busy |=> !LOAD_RVALID)
    else $error("fuse read during EEPROM write");
  // armed fuse read returns fuse bits
  fuse_read_a: assert property (@(posedge CLOCK) disable iff (SRST)
    (LOAD_PROGRAM && state == FSPS_ARMED && ctrl == `FSPS_CMD_FUSE && !eep_busy) |=>
      (LOAD_RVALID && LOAD_RDATA == $past(FUSE_LOCK_BITS)))
    else $error("fuse read lost");
  erase_write_a: assert property (@(posedge CLOCK) disable iff (SRST)
    !(FLASH_ERASE && FLASH_WRITE))
    else $error("erase and write overlap");
  idle_quiet_a: assert property (@(posedge CLOCK) disable iff (SRST)
    state == FSPS_IDLE |=> !FLASH_ERASE && !FLASH_WRITE)
    else $error("flash strobed while idle");
  stream_word_a: assert property (@(posedge CLOCK) disable iff (SRST)
    (FLASH_WRITE && FLASH_WORD != `FSPS_LAST_WORD) |=> FLASH_WORD == $past(FLASH_WORD) + 4'h1)
    else $error("write word skipped");

  // ========================================================================
  // Main scenarios reached
  cov_load_c:  cover property (@(posedge CLOCK) load_en);
  cov_erase_c: cover property (@(posedge CLOCK) state == FSPS_BUSY && ctrl == `FSPS_CMD_ERASE);
  cov_write_c: cover property (@(posedge CLOCK) write_done);
  cov_fuse_c:  cover property (@(posedge CLOCK) LOAD_RVALID);
  cov_lapse_c: cover property (@(posedge CLOCK) state == FSPS_ARMED && arm_cnt == 3'h1 && !store_ok);
endmodule

/* fsps_cpu_model.sv */
// Behavioural CPU core that issues store and load instructions
`timescale 1ns/100ps
module fsps_cpu_model (
  input  wire logic        clock,
  input  wire logic        cpu_halt,
  output logic             store_program,
  output logic             load_program,
  output logic [15:0]      pointer,
  output logic [15:0]      data_pair
);
  // ==========================================================================
  // Idle operands at time zero
  initial begin
    store_program = 1'b0;
    load_program  = 1'b0;
    pointer       = 16'h0000;
    data_pair     = 16'h0000;
  end
  // ==========================================================================
  // One instruction after gap idle cycles; a halted core issues nothing
  // halt-gated timed issue
  task automatic issue(input logic st, input logic [15:0] ptr, input logic [15:0] dat,
                       input int gap);
    repeat (gap) @(posedge clock);
    while (cpu_halt === 1'b1) @(posedge clock);
    store_program <= st;
    load_program  <= ~st;
    pointer       <= ptr;
    data_pair     <= dat;
    @(posedge clock);
    store_program <= 1'b0;
    load_program  <= 1'b0;
    pointer       <= ~ptr;
    data_pair     <= ~dat;
  endtask
endmodule

/* flash_self_program_sequencer_tb.sv */
// Self-checking bench of the flash self-program sequencer
`timescale 1ns/100ps
`include "fsps_map.svh"
module flash_self_program_sequencer_tb;
  import fsps_pkg::*;
  localparam int unsigned PROG = 20;
  logic        clock, srst, reg_wr, reg_rd, fuse_n, ee_busy;
  logic        st, ld, halt, erase, write, byte_hi, rvalid;
  logic [7:0]  addr, wdata, rdata, lrdata, d;
  logic [15:0] ptr;
  logic [6:0]  fpage, pg;
  logic [3:0]  fword;
  fsps_word_t  dpair, fdata;
  fsps_word_t  got[16];
  fsps_word_t  exp_w[16];
  logic [7:0]  codes[8] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h21, 8'hC1, 8'h07, 8'h3F};
  logic [7:0]  want[8]  = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h21, 8'h01, 8'h00, 8'h00};
  int          failures, n_tests, ne, k;
  // ==========================================================================
  // Design, core model and clock
  fsps_sequencer #(.PROG_CYCLES(PROG)) dut_u (.CLOCK(clock), .SRST(srst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata),
    .STORE_PROGRAM(st), .LOAD_PROGRAM(ld), .POINTER(ptr), .DATA_PAIR(dpair),
    .SELF_PROGRAM_FUSE_N(fuse_n), .EEPROM_WRITE_BUSY(ee_busy), .FUSE_LOCK_BITS(8'hC3),
    .CPU_HALT(halt), .FLASH_ERASE(erase), .FLASH_WRITE(write), .FLASH_PAGE(fpage),
    .FLASH_WDATA(fdata), .FLASH_WORD(fword), .LOAD_BYTE_HIGH(byte_hi),
    .LOAD_RDATA(lrdata), .LOAD_RVALID(rvalid));
  fsps_cpu_model cpu_u (.clock(clock), .cpu_halt(halt), .store_program(st),
    .load_program(ld), .pointer(ptr), .data_pair(dpair));
  always #5 clock = ~clock;
  // ==========================================================================
  // Compare, register access and timed operations
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    reg_wr <= 1'b1;
    addr   <= a;
    wdata  <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
    reg_rd <= 1'b1;
    addr   <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    v = rdata;
  endtask
  // Arm, store, then count the halted span and capture the streamed words
  task automatic prog(input logic [7:0] cmd, input logic [15:0] p, input int gap,
                      input logic run);
    int w;
    int n;
    reg_write(`FSPS_CTRL_ADDR, cmd);
    cpu_u.issue(1'b1, p, 16'h5A5A, gap);
    w  = 0;
    n  = 0;
    ne = 0;
    while (halt !== 1'b1 && w < 4) begin
      @(posedge clock);
      w++;
    end
    while (halt === 1'b1 && n < 200) begin
      if (erase === 1'b1) ne++;
      if (write === 1'b1) got[fword] = fdata;
      pg = fpage;
      @(posedge clock);
      n++;
    end
    // Halt only when an armed store was taken
    check("halt_run", n > 0, run);
  endtask
  task automatic load(input int idx, input fsps_word_t v, input int gap);
    reg_write(`FSPS_CTRL_ADDR, `FSPS_CMD_LOAD);
    cpu_u.issue(1'b1, {4'hF, 7'h2B, 4'(idx), 1'b1}, v, gap);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================================
  // Watchdog
  initial begin
    #(20000 * 10);
    failures++;
    stop_test();
  end
  // ==========================================================================
  // Test sequence
  initial begin
    clock    = 1'b0;
    srst     = 1'b1;
    reg_wr   = 1'b0;
    reg_rd   = 1'b0;
    addr     = 8'h00;
    wdata    = 8'h00;
    fuse_n   = 1'b0;
    ee_busy  = 1'b0;
    failures = 0;
    n_tests  = 0;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    reg_read(`FSPS_STAT_ADDR, d);
    check("status", d, 8'h02);
    // Each legal code reads back masked, illegal ones read zero, then all lapse
    for (int i = 0; i < 8; i++) begin
      reg_write(`FSPS_CTRL_ADDR, codes[i]);
      reg_read(`FSPS_CTRL_ADDR, d);
      check("ctrl_arm", d, want[i]);
      repeat (6) @(posedge clock);
      reg_read(`FSPS_CTRL_ADDR, d);
      check("ctrl_lapse", d, 8'h00);
    end
    // Fill in scrambled order at mixed speeds, erase, write
    for (int i = 0; i < 16; i++) begin
      k = (i * 7) % 16;
      exp_w[k] = {4'hA, 4'(k), 8'h5C};
      got[k] = ~exp_w[k];
      load(k, exp_w[k], i % 3);
    end
    prog(`FSPS_CMD_ERASE, {4'hF, 7'h2B, 4'h9, 1'b1}, 3, 1'b1);
    check("erase_len", ne, PROG);
    check("erase_page", pg, 7'h2B);
    prog(`FSPS_CMD_WRITE, {4'h0, 7'h2B, 5'h00}, 0, 1'b1);
    check("write_page", pg, 7'h2B);
    for (int i = 0; i < 16; i++) check("write_word", got[i], exp_w[i]);
    prog(`FSPS_CMD_WRITE, {4'h0, 7'h2B, 5'h00}, 0, 1'b1);
    check("wipe_after_write", got[0] !== exp_w[0], 1'b1);
    // Clear bit empties the buffer
    load(4, 16'h1234, 0);
    reg_write(`FSPS_CTRL_ADDR, `FSPS_CMD_CLEAR);
    repeat (6) @(posedge clock);
    got[4] = 16'h1234;
    prog(`FSPS_CMD_WRITE, {4'h0, 7'h11, 5'h00}, 1, 1'b1);
    check("wipe_on_clear", got[4] !== 16'h1234, 1'b1);
    // EEPROM write blocks programming and discards loads
    load(6, 16'h4321, 0);
    ee_busy <= 1'b1;
    repeat (3) @(posedge clock);
    prog(`FSPS_CMD_ERASE, 16'h0560, 0, 1'b0);
    ee_busy <= 1'b0;
    repeat (3) @(posedge clock);
    got[6] = 16'h4321;
    prog(`FSPS_CMD_WRITE, 16'h0560, 0, 1'b1);
    check("wipe_on_eeprom", got[6] !== 16'h4321, 1'b1);
    // Reset after a load empties the buffer
    load(9, 16'h7777, 0);
    srst <= 1'b1;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    got[9] = 16'h7777;
    prog(`FSPS_CMD_WRITE, 16'h0560, 0, 1'b1);
    check("wipe_on_reset", got[9] !== 16'h7777, 1'b1);
    // Refused stores: illegal code, lapsed window, fuse off
    prog(8'h00, 16'h0560, 0, 1'b0);
    prog(`FSPS_CMD_ERASE, 16'h0560, 4, 1'b0);
    fuse_n <= 1'b1;
    repeat (3) @(posedge clock);
    prog(`FSPS_CMD_ERASE, 16'h0560, 0, 1'b0);
    fuse_n <= 1'b0;
    repeat (3) @(posedge clock);
    // Fuse read through a load with the high byte selected
    reg_write(`FSPS_CTRL_ADDR, `FSPS_CMD_FUSE);
    cpu_u.issue(1'b0, 16'h0001, 16'h0000, 0);
    @(posedge clock);
    check("load_read", {rvalid, byte_hi, lrdata}, {2'b11, 8'hC3});
    stop_test();
  end
endmodule
